// [verilog/bcc_core.sv]
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
// Behaviour
// - Opcode 0101 sets bit b of register f in one cycle and leaves every status flag alone.
// - Opcode 0111 skips the next instruction when bit b of register f is one, with no flag change.
// - A taken skip discards the already fetched instruction and runs a no-op instead, costing two cycles.
// - A call first pushes the current counter value, pc_r unchanged, onto the return stack.
// - A call loads the literal into counter bits 7:0, status bits 6:5 into counter bits 10:9 and clears bit 8.
// - A call is encoded 1001 plus an 8-bit literal, takes two cycles and changes no flag.
// - Encoding 0000 011f ffff writes zero to register f and sets the zero flag in one cycle.
// - The clear-accumulator instruction writes 00h into the accumulator and sets the zero flag.
// - The watchdog kick clears the watchdog counter and, only when the prescaler belongs to it, the prescaler.
// - The watchdog kick 0000 0000 0100 sets both the active-low expiry and sleep flags.
// - Encoding 0010 01df ffff inverts register f and sets the zero flag from the result in one cycle.
// - For the invert, d of 0 writes the accumulator and d of 1 writes register f back.
module bcc_core
  import bcc_pkg::*;
#(
  parameter int FILE_DEPTH = 32
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        instr_valid,
  input  wire logic [11:0] instr_word,
  input  wire logic        expiry_evt,
  input  wire logic        sleep_evt,
  output logic      [10:0] fetch_pc,
  output logic             flush,
  output logic             watchdog_clear,
  output logic             prescaler_clear,
  output logic      [10:0] stack_head
);
  import bcc_pkg::*;

  // ==========================================================
  // State
  logic [7:0]  file_r [FILE_DEPTH];
  logic [1:0]  ctrl_r,   ctrl_nxt;
  logic [7:0]  stat_r,   stat_nxt;
  logic [7:0]  w_r,      w_nxt;
  logic [10:0] pc_r,     pc_nxt;
  logic [10:0] stk0_r,   stk0_nxt;
  logic [10:0] stk1_r,   stk1_nxt;
  logic        flush_r,  flush_nxt;
  logic        wdc_r,    wdc_nxt;
  logic        psc_r,    psc_nxt;
  logic        dph_r,    dph_nxt;
  logic        dwr_r,    dwr_nxt;
  logic [7:0]  dadr_r,   dadr_nxt;
  logic [31:0] rdat_r,   rdat_nxt;

  // ==========================================================
  // Decode
  logic [4:0]  fa;
  logic [2:0]  bi;
  logic [7:0]  fval;
  logic        bitv;
  logic        exec;
  logic        op_set, op_slo, op_shi, op_call, op_zreg, op_zacc, op_kick, op_inv;
  logic        fw_en;
  logic [4:0]  fw_adr;
  logic [7:0]  fw_dat;

  assign fa      = instr_word[BCC_F_HI:BCC_F_LO];
  assign bi      = instr_word[BCC_B_HI:BCC_B_LO];
  assign fval    = file_r[fa];
  assign bitv    = fval[bi];
  // A flushed slot still consumes its fetch but executes nothing
  assign exec    = ctrl_r[BCC_CTRL_RUN] & instr_valid & ~flush_r;
  assign op_set  = exec & (instr_word[11:8] == BCC_OP_SET_BIT);
  assign op_slo  = exec & (instr_word[11:8] == BCC_OP_SKIP_LOW);
  assign op_shi  = exec & (instr_word[11:8] == BCC_OP_SKIP_HIGH);
  assign op_call = exec & (instr_word[11:8] == BCC_OP_CALL);
  assign op_zreg = exec & (instr_word[11:5] == BCC_OP_ZERO_REG);
  assign op_zacc = exec & (instr_word == BCC_OP_ZERO_ACC);
  assign op_kick = exec & (instr_word == BCC_OP_KICK);
  assign op_inv  = exec & (instr_word[11:6] == BCC_OP_INVERT);

  // ==========================================================
  // Execute
  always_comb
  begin
    w_nxt     = w_r;
    stat_nxt  = stat_r;
    pc_nxt    = pc_r;
    stk0_nxt  = stk0_r;
    stk1_nxt  = stk1_r;
    flush_nxt = 1'b0;
    wdc_nxt   = 1'b0;
    psc_nxt   = 1'b0;
    fw_en     = 1'b0;
    fw_adr    = fa;
    fw_dat    = fval;
    // Hardware clears flags first so a kick in the same cycle wins
    if (expiry_evt)
      stat_nxt[BCC_ST_EXP] = 1'b0;
    if (sleep_evt)
      stat_nxt[BCC_ST_SLEEP] = 1'b0;
    if (ctrl_r[BCC_CTRL_RUN] && instr_valid)
      pc_nxt = 11'(pc_r + 11'h001);
    if (op_set)
    begin
      fw_en      = 1'b1;
      fw_dat[bi] = 1'b1;
    end
    if ((op_shi && bitv) || (op_slo && !bitv))
      flush_nxt = 1'b1;
    if (op_call)
    begin
      stk1_nxt  = stk0_r;
      stk0_nxt  = pc_r;
      pc_nxt    = {stat_r[BCC_ST_PG_HI:BCC_ST_PG_LO], 1'b0, instr_word[7:0]};
      flush_nxt = 1'b1;
    end
    if (op_zreg)
    begin
      fw_en             = 1'b1;
      fw_dat            = 8'h00;
      stat_nxt[BCC_ST_Z] = 1'b1;
    end
    if (op_zacc)
    begin
      w_nxt              = 8'h00;
      stat_nxt[BCC_ST_Z] = 1'b1;
    end
    if (op_kick)
    begin
      wdc_nxt                = 1'b1;
      psc_nxt                = ctrl_r[BCC_CTRL_PSA];
      stat_nxt[BCC_ST_EXP]   = 1'b1;
      stat_nxt[BCC_ST_SLEEP] = 1'b1;
    end
    if (op_inv)
    begin
      stat_nxt[BCC_ST_Z] = (fval == 8'hFF);
      if (instr_word[BCC_D])
      begin
        fw_en  = 1'b1;
        fw_dat = ~fval;
      end
      else
        w_nxt = ~fval;
    end
    // Bus writes to state the core did not touch this cycle; a core write to any file register blocks every bus file write
    ctrl_nxt = ctrl_r;
    if (dph_r && dwr_r)
    begin
      if (dadr_r == BCC_OFS_CTRL)
        ctrl_nxt = hwdata[1:0];
      else if (dadr_r == BCC_OFS_STAT)
        stat_nxt[BCC_ST_PG_HI:BCC_ST_PG_LO] = hwdata[BCC_ST_PG_HI:BCC_ST_PG_LO];
      else if (dadr_r == BCC_OFS_ACCUM && !(op_zacc || (op_inv && !instr_word[BCC_D])))
        w_nxt = hwdata[7:0];
      else if (dadr_r >= BCC_OFS_FILE && !fw_en)
      begin
        fw_en  = 1'b1;
        fw_adr = dadr_r[6:2];
        fw_dat = hwdata[7:0];
      end
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  always_comb
  begin
    dph_nxt  = hsel & hready & htrans[1];
    dwr_nxt  = hwrite;
    dadr_nxt = haddr[7:0];
    rdat_nxt = 32'h0000_0000;
    if (dph_nxt && !hwrite)
    begin
      if (haddr[7:0] == BCC_OFS_CTRL)
        rdat_nxt = {30'h0000_0000, ctrl_r};
      else if (haddr[7:0] == BCC_OFS_STAT)
        rdat_nxt = {24'h00_0000, stat_r};
      else if (haddr[7:0] == BCC_OFS_ACCUM)
        rdat_nxt = {24'h00_0000, w_r};
      else if (haddr[7:0] == BCC_OFS_PC)
        rdat_nxt = {21'h00_0000, pc_r};
      else if (haddr[7:0] == BCC_OFS_STACK)
        rdat_nxt = {21'h00_0000, stk0_r};
      else if (haddr[7:0] >= BCC_OFS_FILE)
        rdat_nxt = {24'h00_0000, file_r[haddr[6:2]]};
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r  <= BCC_CTRL_RST;
      stat_r  <= BCC_STAT_RST;
      w_r     <= 8'h00;
      pc_r    <= BCC_PC_RST;
      stk0_r  <= BCC_PC_RST;
      stk1_r  <= BCC_PC_RST;
      flush_r <= 1'b0;
      wdc_r   <= 1'b0;
      psc_r   <= 1'b0;
      dph_r   <= 1'b0;
      dwr_r   <= 1'b0;
      dadr_r  <= 8'h00;
      rdat_r  <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      stat_r  <= stat_nxt;
      w_r     <= w_nxt;
      pc_r    <= pc_nxt;
      stk0_r  <= stk0_nxt;
      stk1_r  <= stk1_nxt;
      flush_r <= flush_nxt;
      wdc_r   <= wdc_nxt;
      psc_r   <= psc_nxt;
      dph_r   <= dph_nxt;
      dwr_r   <= dwr_nxt;
      dadr_r  <= dadr_nxt;
      rdat_r  <= rdat_nxt;
    end
  end

  // Data memory has no reset, like the real file
  always_ff @(posedge hclk)
  begin
    if (fw_en)
      file_r[fw_adr] <= fw_dat;
  end

  assign hrdata          = rdat_r;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign fetch_pc        = pc_r;
  assign flush           = flush_r;
  assign watchdog_clear  = wdc_r;
  assign prescaler_clear = psc_r;
  assign stack_head      = stk0_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_call_issue;
    op_call;
  endsequence
  sequence s_call_bubble;
    flush_r ##1 !flush_r || op_call;
  endsequence

  a_set_bit_write: assert property (op_set && !(dph_r && dwr_r) |=> file_r[$past(fa)][$past(bi)]
                                    && stat_r[BCC_ST_Z] == $past(stat_r[BCC_ST_Z]))
    else $error("bit set missed");
  a_skip_high_flush: assert property (op_shi |=> flush_r == $past(bitv))
    else $error("skip on high bit wrong");
  a_skip_low_flush: assert property (op_slo |=> flush_r == !$past(bitv))
    else $error("skip on low bit wrong");
  a_flush_nop_slot: assert property (flush_r && instr_valid && !(dph_r && dwr_r) |=> $stable(w_r))
    else $error("flushed slot executed");
  a_call_push_ret: assert property (op_call |=> stk0_r == $past(pc_r) && stk1_r == $past(stk0_r))
    else $error("call push wrong");
  a_call_target_pc: assert property (op_call |=> pc_r == {$past(stat_r[6:5]), 1'b0, $past(instr_word[7:0])})
    else $error("call target wrong");
  a_call_two_cycle: assert property (s_call_issue |=> s_call_bubble)
    else $error("call not two cycles");
  a_zero_reg_op: assert property (op_zreg |=> file_r[$past(fa)] == 8'h00 && stat_r[BCC_ST_Z])
    else $error("register clear wrong");
  a_zero_acc_op: assert property (op_zacc |=> w_r == 8'h00 && stat_r[BCC_ST_Z])
    else $error("accumulator clear wrong");
  a_kick_prescaler: assert property (op_kick |=> watchdog_clear && prescaler_clear == $past(ctrl_r[1]))
    else $error("watchdog clear wrong");
  a_kick_flags_set: assert property (op_kick |=> stat_r[BCC_ST_EXP] && stat_r[BCC_ST_SLEEP])
    else $error("kick flags not set");
  a_invert_to_acc: assert property (op_inv && !instr_word[BCC_D] && !(dph_r && dwr_r)
                                    |=> w_r == ~$past(fval) && stat_r[BCC_ST_Z] == (w_r == 8'h00))
    else $error("invert to accumulator wrong");
  a_invert_to_reg: assert property (op_inv && instr_word[BCC_D] |=> file_r[$past(fa)] == ~$past(fval))
    else $error("invert to register wrong");
  a_flush_file_hold: assert property (flush_r && instr_valid && !(dph_r && dwr_r)
                                      |=> file_r[$past(fa)] == $past(fval))
    else $error("flushed slot wrote file");
  a_quiet_ops_stat: assert property ((op_set || op_shi || op_slo || op_call)
                                     && !expiry_evt && !sleep_evt && !(dph_r && dwr_r) |=> $stable(stat_r))
    else $error("flag changed by flagless op");
  a_pc_step_one: assert property (ctrl_r[BCC_CTRL_RUN] && instr_valid && !op_call
                                  |=> pc_r == 11'($past(pc_r) + 11'h001))
    else $error("counter did not step");

endmodule : bcc_core

// [include/bcc_pkg.sv]
package bcc_pkg;

  // ==========================================================
  // Bus map (byte addresses)
  localparam logic [7:0] BCC_OFS_CTRL  = 8'h00;
  localparam logic [7:0] BCC_OFS_STAT  = 8'h04;
  localparam logic [7:0] BCC_OFS_ACCUM = 8'h08;
  localparam logic [7:0] BCC_OFS_PC    = 8'h0C;
  localparam logic [7:0] BCC_OFS_STACK = 8'h10;
  localparam logic [7:0] BCC_OFS_FILE  = 8'h80;

  // ==========================================================
  // Control register fields
  localparam int BCC_CTRL_RUN  = 0;
  localparam int BCC_CTRL_PSA  = 1;
  localparam logic [1:0] BCC_CTRL_RST = 2'h0;

  // ==========================================================
  // Status byte fields
  localparam int BCC_ST_Z     = 2;
  localparam int BCC_ST_SLEEP = 3;
  localparam int BCC_ST_EXP   = 4;
  localparam int BCC_ST_PG_LO = 5;
  localparam int BCC_ST_PG_HI = 6;
  localparam logic [7:0] BCC_STAT_RST = 8'h18;

  // ==========================================================
  // Instruction field layout
  localparam int BCC_F_LO = 0;
  localparam int BCC_F_HI = 4;
  localparam int BCC_B_LO = 5;
  localparam int BCC_B_HI = 7;
  localparam int BCC_D    = 5;

  // ==========================================================
  // Opcodes
  localparam logic [3:0]  BCC_OP_SET_BIT   = 4'h5;
  localparam logic [3:0]  BCC_OP_SKIP_LOW  = 4'h6;
  localparam logic [3:0]  BCC_OP_SKIP_HIGH = 4'h7;
  localparam logic [3:0]  BCC_OP_CALL      = 4'h9;
  localparam logic [6:0]  BCC_OP_ZERO_REG  = 7'h03;
  localparam logic [5:0]  BCC_OP_INVERT    = 6'h09;
  localparam logic [11:0] BCC_OP_ZERO_ACC  = 12'h040;
  localparam logic [11:0] BCC_OP_KICK      = 12'h004;

  localparam logic [10:0] BCC_PC_RST = 11'h000;

endpackage : bcc_pkg

// [dv/bcc_core_bench.sv]
`timescale 1ns/10ps
module bcc_core_bench;
  import bcc_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        instr_valid;
  logic [11:0] instr_word;
  logic        expiry_evt;
  logic        sleep_evt;
  logic [10:0] fetch_pc;
  logic        flush;
  logic        watchdog_clear;
  logic        prescaler_clear;
  logic [10:0] stack_head;
  logic [31:0] d;
  logic [31:0] s;
  logic [10:0] p;
  int          fail_count;
  int          n_checks;

  bcc_core bcc_core_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .instr_valid(instr_valid), .instr_word(instr_word), .expiry_evt(expiry_evt),
    .sleep_evt(sleep_evt), .fetch_pc(fetch_pc), .flush(flush), .watchdog_clear(watchdog_clear),
    .prescaler_clear(prescaler_clear), .stack_head(stack_head)
  );

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // ==========================================================
  // Shared tasks
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Open-ended wait; a stuck hready ends in the watchdog
  task automatic wait_rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  function automatic logic [7:0] fa(input logic [4:0] f);
    return BCC_OFS_FILE + {1'b0, f, 2'b00};
  endfunction : fa

  // Results show one edge later, read there before that edge updates them
  task automatic exec(input logic [11:0] w);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge hclk);
  endtask : exec

  task automatic idle;
    instr_valid <= 1'b0;
    @(posedge hclk);
  endtask : idle

  // ==========================================================
  // Scenarios
  task automatic test_bits;
    bus(1'b1, fa(5'd3), 32'h0000000A, d);
    bus(1'b0, BCC_OFS_STAT, 32'h0, s);
    exec(12'h5E3);
    idle();
    bus(1'b0, fa(5'd3), 32'h0, d);
    chk(d, 32'h0000008A);
    p = fetch_pc;
    exec(12'h7E3);
    exec(12'h503);
    chk({31'h0, flush}, 32'h1);
    exec(12'h703);
    chk({31'h0, flush}, 32'h0);
    chk({21'h0, fetch_pc}, {21'h0, p + 11'h002});
    exec(12'h6E3);
    chk({31'h0, flush}, 32'h0);
    exec(12'h603);
    chk({31'h0, flush}, 32'h0);
    exec(12'h503);
    chk({31'h0, flush}, 32'h1);
    idle();
    bus(1'b0, fa(5'd3), 32'h0, d);
    chk(d, 32'h0000008A);
    bus(1'b0, BCC_OFS_STAT, 32'h0, d);
    chk(d, s);
    $display("test bits done");
  endtask : test_bits

  task automatic test_call;
    bus(1'b1, BCC_OFS_STAT, 32'h00000060, d);
    bus(1'b0, BCC_OFS_STAT, 32'h0, s);
    chk(s & 32'h60, 32'h60);
    p = fetch_pc;
    exec(12'h9A5);
    exec(12'h503);
    chk({21'h0, fetch_pc}, 32'h000006A5);
    chk({21'h0, stack_head}, {21'h0, p});
    chk({31'h0, flush}, 32'h1);
    idle();
    chk({21'h0, fetch_pc}, 32'h000006A6);
    bus(1'b0, BCC_OFS_STAT, 32'h0, d);
    chk(d, s);
    bus(1'b0, fa(5'd3), 32'h0, d);
    chk(d, 32'h0000008A);
    $display("test call done");
  endtask : test_call

  task automatic zchk(input logic [31:0] exp);
    bus(1'b0, BCC_OFS_STAT, 32'h0, d);
    chk({31'h0, d[BCC_ST_Z]}, exp);
  endtask : zchk

  task automatic test_clear;
    bus(1'b1, fa(5'd6), 32'h00000013, d);
    bus(1'b1, fa(5'd5), 32'h0000005A, d);
    bus(1'b1, fa(5'd7), 32'h000000FF, d);
    exec(12'h246);
    idle();
    bus(1'b0, BCC_OFS_ACCUM, 32'h0, d);
    chk(d, 32'h000000EC);
    zchk(32'h0);
    exec(12'h040);
    idle();
    bus(1'b0, BCC_OFS_ACCUM, 32'h0, d);
    chk(d, 32'h0);
    zchk(32'h1);
    exec(12'h266);
    idle();
    bus(1'b0, fa(5'd6), 32'h0, d);
    chk(d, 32'h000000EC);
    zchk(32'h0);
    exec(12'h065);
    idle();
    bus(1'b0, fa(5'd5), 32'h0, d);
    chk(d, 32'h0);
    zchk(32'h1);
    exec(12'h266);
    exec(12'h267);
    idle();
    bus(1'b0, fa(5'd7), 32'h0, d);
    chk(d, 32'h0);
    zchk(32'h1);
    bus(1'b0, BCC_OFS_ACCUM, 32'h0, d);
    chk(d, 32'h0);
    $display("test clear done");
  endtask : test_clear

  task automatic test_kick;
    expiry_evt <= 1'b1;
    sleep_evt  <= 1'b1;
    @(posedge hclk);
    expiry_evt <= 1'b0;
    sleep_evt  <= 1'b0;
    @(posedge hclk);
    bus(1'b0, BCC_OFS_STAT, 32'h0, d);
    chk(d & 32'h18, 32'h0);
    exec(12'h004);
    idle();
    chk({30'h0, watchdog_clear, prescaler_clear}, 32'h2);
    idle();
    chk({30'h0, watchdog_clear, prescaler_clear}, 32'h0);
    bus(1'b0, BCC_OFS_STAT, 32'h0, d);
    chk(d & 32'h18, 32'h18);
    bus(1'b1, BCC_OFS_CTRL, 32'h00000003, d);
    exec(12'h004);
    idle();
    chk({30'h0, watchdog_clear, prescaler_clear}, 32'h3);
    $display("test kick done");
  endtask : test_kick

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    fail_count = 0;
    n_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    instr_valid = 1'b0;
    instr_word = 12'h000;
    expiry_evt = 1'b0;
    sleep_evt = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, BCC_OFS_STAT, 32'h0, d);
    chk(d, {24'h0, BCC_STAT_RST});
    bus(1'b1, BCC_OFS_CTRL, 32'h00000001, d);
    test_bits();
    test_call();
    test_clear();
    test_kick();
    conclude();
  end

  // Whole run is about a hundred cycles; generous margin
  initial
  begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    conclude();
  end
endmodule : bcc_core_bench
